// file: dmsp_host.sv
// host model: spi or i2c master driving the serial register port
`default_nettype none
module dmsp_host (
  // lines driven by the host
  output logic sck,
  output logic cs_n,
  output logic sd,
  // lines seen by the host
  input wire logic so,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // half period of the 48 ns spi clock, quarter bit of 400 kbit/s i2c
  localparam int H = 24;
  localparam int Q = 625;
  // idle: clock high, select off, data released
  initial begin
    sck <= 1'b1;
    cs_n <= 1'b1;
    sd <= 1'b1;
  end
  // idle clock level at select fall picks the bit order
  task spi_begin(input logic lsb);
    sck <= lsb;
    #H cs_n <= 1'b0;
    #H;
  endtask
  // shifts n bits from seq[7] down; so taken midway through sck high,
  // since the port needs a few core clocks to move so after the fall
  task spi_byte(input logic [7:0] seq, input int n, output logic [7:0] got);
    got = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck <= 1'b0;
      sd <= seq[i];
      #H sck <= 1'b1;
      #(H / 2) got[i] = so;
      #(H / 2);
    end
  endtask
  // select held low until the last bit, then si no longer means anything
  task spi_end();
    #H cs_n <= 1'b1;
    sd <= ~sd;
  endtask
  // start, also used as repeated start
  task i2c_start();
    sd <= 1'b1;
    #Q sck <= 1'b1;
    #Q sd <= 1'b0;
    #Q sck <= 1'b0;
    #Q;
  endtask
  task i2c_stop();
    sd <= 1'b0;
    #Q sck <= 1'b1;
    #Q sd <= 1'b1;
    #Q;
  endtask
  // one bit slot; the wire is read in the middle of scl high
  task i2c_bit(input logic b, output logic got);
    sd <= b;
    #Q sck <= 1'b1;
    #Q got = sda;
    #Q sck <= 1'b0;
    #Q;
  endtask
  task i2c_wbyte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], g);
    end
    i2c_bit(1'b1, g);
    ack = ~g;
  endtask
  // last byte of a read is not acknowledged
  task i2c_rbyte(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(1'b1, b[i]);
    end
    i2c_bit(last, g);
  endtask
endmodule
`default_nettype wire

// file: dmsp_pkg.sv
// shared constants and types of the dual mode serial register port
`default_nettype none
package dmsp_pkg;
  // register map limits and the page pointer location
  localparam logic [6:0] DMSP_ADDR_MAX = 7'h7f;
  localparam logic [6:0] DMSP_PAGE_PTR_ADDR = 7'h64;
  localparam logic [3:0] DMSP_PAGE_RST = 4'h0;
  localparam int DMSP_PAGE_W = 4;
  localparam int DMSP_ADDR_W = 7;
  localparam int DMSP_DATA_W = 8;
  // bit counter values
  localparam logic [3:0] DMSP_CNT_RST = 4'h0;
  localparam logic [3:0] DMSP_SPI_LAST = 4'h7;
  localparam logic [3:0] DMSP_I2C_BYTE = 4'h8;
  // value returned for reads past the top address
  localparam logic [7:0] DMSP_IDLE_BYTE = 8'hff;
  // pin vector positions after the synchroniser
  localparam int DMSP_P_SDA = 0;
  localparam int DMSP_P_SCK = 1;
  localparam int DMSP_P_CS = 2;
  localparam int DMSP_P_EN = 3;
  localparam int DMSP_PINS = 4;
  localparam logic [3:0] DMSP_PIN_RST = 4'hf;
  // reset low time and its count at the core clock
  localparam int DMSP_CLK_MHZ = 200;
  localparam int DMSP_RST_MIN_NS = 300;
  localparam int DMSP_RST_MIN_CYC =
    (DMSP_RST_MIN_NS * DMSP_CLK_MHZ + 999) / 1000;
  // i2c slave states
  typedef enum logic [3:0] {
    DMSP_I_IDLE, DMSP_I_DEV, DMSP_I_DEV_ACK, DMSP_I_REG,
    DMSP_I_REG_ACK, DMSP_I_WR, DMSP_I_WR_ACK, DMSP_I_RD,
    DMSP_I_RD_ACK, DMSP_I_SKIP
  } dmsp_i2c_e;
endpackage
`default_nettype wire

// file: dmsp_port.sv
// spi or i2c slave giving a host access to the register map
`default_nettype none
// What this block does
// - strap high i2c, strap low spi
// - sck level at select picks bit order
// - spi frame: 7-bit address, 8-bit bytes
// - chip select high resets spi logic
// - first address bit: 1 read, 0 write
// - spi burst increments address per byte
// - half duplex: ignore other direction
// - i2c slave, 7-bit address, both rates
// - i2c bytes msb first, each acknowledged
// - i2c write: device, register, data bytes
// - i2c read: set address, then read
// - slave address: fixed six bits plus pin
// - i2c burst uses incremented addresses
// - stop at top address, never wrap
// - reset brings all defaults
// - read strobe lets map clear sticky bits
// - multi-byte order kept by register map
// - page pointer selects page, resets zero
module dmsp_port
  import dmsp_pkg::*;
#(
  parameter logic [5:0] I2C_FIXED_ADDR = 6'h2a // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins
  input wire logic i2c_en,
  input wire logic chip_select_addr_pin,
  input wire logic sck_scl,
  input wire logic si_sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic so_out,
  output logic so_oe_n,
  // register map side
  output logic [dmsp_pkg::DMSP_PAGE_W+dmsp_pkg::DMSP_ADDR_W-1:0] reg_addr,
  output logic [dmsp_pkg::DMSP_DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [dmsp_pkg::DMSP_DATA_W-1:0] reg_rd_data,
  // mode seen by the port
  output logic i2c_mode
);
  import dmsp_pkg::*;

  logic [DMSP_PINS-1:0] f, f_d, next_f_d;
  logic lsb, rw, ph, fresh, pend, over;
  logic [3:0] cnt;
  logic [7:0] sh, tx;
  logic [6:0] addr;
  logic [3:0] page;
  dmsp_i2c_e st;
  logic next_mode, next_lsb, next_rw, next_ph, next_fresh, next_pend;
  logic next_over, next_reg_wr, next_reg_rd;
  logic next_so, next_so_oe_n, next_sda_oe_n;
  logic [3:0] next_cnt, next_page;
  logic [7:0] next_sh, next_tx, next_wdata;
  logic [6:0] next_addr;
  logic [10:0] next_reg_addr;
  dmsp_i2c_e next_st;
  logic sda_f, sck_f, cs_f, en_f;
  logic rise, fall, cs_fell, start, stop, dev_hit;

  // shift one bit in, order chosen by the host at select
  function automatic logic [7:0] shin(input logic [7:0] s,
                                      input logic b, input logic l);
    shin = l ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  // shift the outgoing byte one place
  function automatic logic [7:0] shout(input logic [7:0] s,
                                       input logic l);
    shout = l ? {1'b0, s[7:1]} : {s[6:0], 1'b0};
  endfunction

  // bit that is on the wire next
  function automatic logic pick(input logic [7:0] s, input logic l);
    pick = l ? s[0] : s[7];
  endfunction

  // pins pass three flops and the filter flop before anything looks at them
  dmsp_sync3 #(.W(DMSP_PINS), .INIT(DMSP_PIN_RST)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({i2c_en, chip_select_addr_pin, sck_scl, si_sda_in}),
    .dout(f)
  );

  // filtered levels and their edges
  assign sda_f = f[DMSP_P_SDA];
  assign sck_f = f[DMSP_P_SCK];
  assign cs_f = f[DMSP_P_CS];
  assign en_f = f[DMSP_P_EN];
  assign rise = sck_f & ~f_d[DMSP_P_SCK];
  assign fall = ~sck_f & f_d[DMSP_P_SCK];
  assign cs_fell = ~cs_f & f_d[DMSP_P_CS];
  assign start = sck_f & f_d[DMSP_P_SCK] & f_d[DMSP_P_SDA] & ~sda_f;
  assign stop = sck_f & f_d[DMSP_P_SCK] & ~f_d[DMSP_P_SDA] & sda_f;
  assign dev_hit = (sh[7:1] == {I2C_FIXED_ADDR, cs_f});

  // next state of the whole port, both modes
  always_comb begin
    logic rd_go, wr_go, inc_go, drv_go, dbit;
    logic [7:0] nsh, ntx;
    rd_go = 1'b0;
    wr_go = 1'b0;
    inc_go = 1'b0;
    drv_go = 1'b0;
    dbit = 1'b1;
    nsh = shin(sh, sda_f, lsb);
    ntx = shout(tx, lsb);
    next_f_d = f;
    next_mode = en_f;
    next_lsb = lsb;
    next_rw = rw;
    next_ph = ph;
    next_fresh = fresh;
    next_pend = 1'b0;
    next_over = over;
    next_cnt = cnt;
    next_sh = sh;
    next_tx = pend ? reg_rd_data : tx;
    next_addr = addr;
    next_page = page;
    next_st = st;
    next_reg_wr = 1'b0;
    next_reg_rd = 1'b0;
    next_reg_addr = reg_addr;
    next_wdata = reg_wdata;
    next_so = so_out;
    next_so_oe_n = so_oe_n;
    next_sda_oe_n = sda_oe_n;
    if (!i2c_mode) begin
      next_st = DMSP_I_IDLE;
      next_sda_oe_n = 1'b1;
      if (cs_f) begin
        // partial frames are dropped while deselected
        next_cnt = DMSP_CNT_RST;
        next_ph = 1'b0;
        next_over = 1'b0;
        next_so_oe_n = 1'b1;
      end else begin
        if (cs_fell) begin
          next_lsb = sck_f;
        end
        if (rise) begin
          next_sh = nsh;
          next_cnt = cnt + 4'h1;
          if (!ph && cnt == DMSP_CNT_RST) begin
            next_rw = sda_f;
          end
          if (cnt == DMSP_SPI_LAST) begin
            next_cnt = DMSP_CNT_RST;
            if (!ph) begin
              next_ph = 1'b1;
              next_addr = lsb ? nsh[7:1] : nsh[6:0];
              rd_go = rw;
            end else if (rw) begin
              inc_go = 1'b1;
              rd_go = 1'b1;
            end else begin
              wr_go = 1'b1;
              inc_go = 1'b1;
            end
          end
        end
        // so stays released unless a read byte is going out
        if (fall && ph && rw) begin
          drv_go = 1'b1;
        end
      end
    end else begin
      next_so_oe_n = 1'b1;
      next_lsb = 1'b0;
      if (start) begin
        next_st = DMSP_I_DEV;
        next_cnt = DMSP_CNT_RST;
        next_sda_oe_n = 1'b1;
      end else if (stop) begin
        next_st = DMSP_I_IDLE;
        next_sda_oe_n = 1'b1;
      end else begin
        case (st)
          DMSP_I_DEV, DMSP_I_REG, DMSP_I_WR: begin
            if (rise) begin
              next_sh = shin(sh, sda_f, 1'b0);
              next_cnt = cnt + 4'h1;
            end
            if (fall && cnt == DMSP_I2C_BYTE) begin
              next_cnt = DMSP_CNT_RST;
              next_sda_oe_n = 1'b0;
              if (st == DMSP_I_DEV) begin
                if (dev_hit) begin
                  next_rw = sh[0];
                  rd_go = sh[0];
                  next_st = DMSP_I_DEV_ACK;
                end else begin
                  next_sda_oe_n = 1'b1;
                  next_st = DMSP_I_SKIP;
                end
              end else if (st == DMSP_I_REG) begin
                next_addr = sh[6:0];
                next_over = 1'b0;
                next_st = DMSP_I_REG_ACK;
              end else begin
                wr_go = 1'b1;
                inc_go = 1'b1;
                next_st = DMSP_I_WR_ACK;
              end
            end
          end
          DMSP_I_DEV_ACK: begin
            if (fall) begin
              next_cnt = DMSP_CNT_RST;
              next_sda_oe_n = 1'b1;
              next_st = rw ? DMSP_I_RD : DMSP_I_REG;
              drv_go = rw;
            end
          end
          DMSP_I_REG_ACK, DMSP_I_WR_ACK: begin
            if (fall) begin
              next_cnt = DMSP_CNT_RST;
              next_sda_oe_n = 1'b1;
              next_st = DMSP_I_WR;
            end
          end
          DMSP_I_RD: begin
            if (rise) begin
              next_cnt = cnt + 4'h1;
            end
            if (fall) begin
              if (cnt == DMSP_I2C_BYTE) begin
                next_sda_oe_n = 1'b1;
                next_st = DMSP_I_RD_ACK;
              end else begin
                drv_go = 1'b1;
              end
            end
          end
          DMSP_I_RD_ACK: begin
            if (rise) begin
              if (sda_f) begin
                next_st = DMSP_I_SKIP;
              end else begin
                inc_go = 1'b1;
                rd_go = 1'b1;
              end
            end
            if (fall) begin
              next_cnt = DMSP_CNT_RST;
              next_st = DMSP_I_RD;
              drv_go = 1'b1;
            end
          end
          DMSP_I_IDLE, DMSP_I_SKIP: begin
            next_sda_oe_n = 1'b1;
          end
          default: begin
            next_st = DMSP_I_IDLE;
          end
        endcase
      end
    end
    // write at the current address before any increment
    if (wr_go && !next_over) begin
      next_reg_wr = 1'b1;
      next_wdata = next_sh;
      next_reg_addr = {page, next_addr};
      if (next_addr == DMSP_PAGE_PTR_ADDR) begin
        next_page = next_sh[3:0];
      end
    end
    // saturate at the top address instead of wrapping
    if (inc_go && !next_over) begin
      if (next_addr == DMSP_ADDR_MAX) begin
        next_over = 1'b1;
      end else begin
        next_addr = next_addr + 7'h01;
      end
    end
    // read strobe doubles as the sticky clear request
    if (rd_go) begin
      next_fresh = 1'b1;
      if (!next_over) begin
        next_reg_rd = 1'b1;
        next_reg_addr = {page, next_addr};
        next_pend = 1'b1;
      end else begin
        next_tx = DMSP_IDLE_BYTE;
      end
    end
    // first bit of a byte goes out unshifted
    if (drv_go) begin
      if (fresh) begin
        dbit = pick(tx, lsb);
        next_fresh = 1'b0;
      end else begin
        next_tx = ntx;
        dbit = pick(ntx, lsb);
      end
      if (i2c_mode) begin
        next_sda_oe_n = dbit;
      end else begin
        next_so = dbit;
        next_so_oe_n = 1'b0;
      end
    end
  end

  // all state registered; outputs come straight from here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f_d <= DMSP_PIN_RST;
      i2c_mode <= 1'b1;
      lsb <= 1'b0;
      rw <= 1'b0;
      ph <= 1'b0;
      fresh <= 1'b0;
      pend <= 1'b0;
      over <= 1'b0;
      cnt <= DMSP_CNT_RST;
      sh <= 8'h00;
      tx <= 8'h00;
      addr <= 7'h00;
      page <= DMSP_PAGE_RST;
      st <= DMSP_I_IDLE;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= 11'h000;
      reg_wdata <= 8'h00;
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      f_d <= next_f_d;
      i2c_mode <= next_mode;
      lsb <= next_lsb;
      rw <= next_rw;
      ph <= next_ph;
      fresh <= next_fresh;
      pend <= next_pend;
      over <= next_over;
      cnt <= next_cnt;
      sh <= next_sh;
      tx <= next_tx;
      addr <= next_addr;
      page <= next_page;
      st <= next_st;
      reg_wr <= next_reg_wr;
      reg_rd <= next_reg_rd;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_wdata;
      so_out <= next_so;
      so_oe_n <= next_so_oe_n;
      sda_out <= 1'b0;
      sda_oe_n <= next_sda_oe_n;
    end
  end

  // checks and scenarios
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cs_holds_reset: assert property ((!i2c_mode && cs_f) |=>
    (cnt == DMSP_CNT_RST && so_oe_n && !ph))
    else $error("spi not held in reset while deselected");
  a_spi_no_sda: assert property (!i2c_mode |=> sda_oe_n)
    else $error("sda driven in spi mode");
  a_order_pick: assert property ((!i2c_mode && cs_fell) |=>
    lsb == $past(sck_f))
    else $error("bit order not taken at select");
  a_write_quiet: assert property ((!i2c_mode && ph && !rw) |->
    so_oe_n)
    else $error("so driven during spi write");
  a_read_load: assert property (reg_rd |=>
    tx == $past(reg_rd_data))
    else $error("read data not loaded after strobe");
  a_page_take: assert property ((reg_wr &&
    reg_addr[6:0] == DMSP_PAGE_PTR_ADDR) |-> page == reg_wdata[3:0])
    else $error("page pointer not updated");
  a_no_wrap: assert property (over |-> addr == DMSP_ADDR_MAX)
    else $error("address wrapped past top");
  a_burst_step: assert property ((reg_wr && !over) |->
    addr == reg_addr[6:0] + 7'h01)
    else $error("address not incremented after write");
  a_dev_ack: assert property ((st == DMSP_I_DEV_ACK) |->
    (dev_hit && !sda_oe_n))
    else $error("ack given to wrong slave address");
  a_byte_ack: assert property ((st == DMSP_I_WR_ACK ||
    st == DMSP_I_REG_ACK) |-> !sda_oe_n)
    else $error("byte not acknowledged");
  a_strobe_one: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");

  c_spi_write: cover property (!i2c_mode && reg_wr);
  c_spi_read: cover property (!i2c_mode && reg_rd && lsb);
  c_i2c_write: cover property (i2c_mode && reg_wr);
  c_i2c_read: cover property (st == DMSP_I_RD_ACK ##1 reg_rd);
endmodule
`default_nettype wire

// file: dmsp_sync3.sv
// three flop pin synchroniser with agreement filter
`default_nettype none
module dmsp_sync3 #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pins in, filtered levels out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1, s2, s3;
  logic [W-1:0] next_dout;

  // a bit changes only once stages two and three agree
  always_comb begin
    next_dout = (s2 & s3) | (dout & (s2 ^ s3));
  end

  // s1 feeds s2 only, never the filter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench of the dual mode serial register port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import dmsp_pkg::*;
  localparam logic [5:0] SLV = 6'h15; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic i2c_en = 1'b0;
  logic sck, cs_n, sd, si_sda, sda_out, sda_oe_n, so_out, so_oe_n;
  logic reg_wr, reg_rd, i2c_mode, so_line;
  logic [10:0] reg_addr;
  logic [7:0] reg_wdata, rd_data;
  logic [7:0] mem [128];
  logic [18:0] wlog [$];
  int nrd = 0;
  int mismatches = 0;
  int checked = 0;

  always #2.5 clk = ~clk;
  // open drain wire with pull-up; map answers from the held address
  assign si_sda = sd & (sda_oe_n | sda_out);
  assign rd_data = mem[reg_addr[6:0]];
  // released so reads inverted, so a late output enable shows up
  assign so_line = so_oe_n ? ~so_out : so_out;

  dmsp_port #(.I2C_FIXED_ADDR(SLV)) u_dmsp_port (
    .clk(clk), .rst(rst), .i2c_en(i2c_en),
    .chip_select_addr_pin(cs_n), .sck_scl(sck), .si_sda_in(si_sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .so_out(so_out),
    .so_oe_n(so_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(rd_data),
    .i2c_mode(i2c_mode)
  );
  dmsp_host u_dmsp_host (
    .sck(sck), .cs_n(cs_n), .sd(sd), .so(so_line), .sda(si_sda)
  );

  // register map model: logs writes, counts read strobes
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      wlog.push_back({reg_addr, reg_wdata});
      mem[reg_addr[6:0]] <= reg_wdata;
    end
    if (reg_rd === 1'b1) begin
      nrd++;
    end
  end

  task check(input logic [18:0] seen, input logic [18:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // strap is only changed under reset, as it is static in use
  task do_reset(input logic mode);
    @(posedge clk);
    rst <= 1'b1;
    i2c_en <= mode;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
    check(19'(sda_oe_n & so_oe_n), 19'h1);
    check(19'(i2c_mode), 19'(mode));
    wlog.delete();
  endtask

  // one spi access: rw bit, address, then n data bytes, lowest first
  task spi_acc(input logic lsb, input logic rw, input logic [6:0] a,
               input int n, input logic [15:0] d, output logic [15:0] q);
    logic [7:0] g;
    q = 16'h0000;
    u_dmsp_host.spi_begin(lsb);
    g = rev8({1'b0, a});
    u_dmsp_host.spi_byte(lsb ? {rw, g[7:1]} : {rw, a}, 8, g);
    for (int i = 0; i < n; i++) begin
      u_dmsp_host.spi_byte(lsb ? rev8(d[8*i +: 8]) : d[8*i +: 8], 8, g);
      q[8*i +: 8] = lsb ? rev8(g) : g;
    end
    u_dmsp_host.spi_end();
    repeat (8) @(posedge clk);
  endtask

  task spi_wr(input logic lsb, input logic [6:0] a, input int n,
              input logic [15:0] d, input int nw);
    logic [15:0] q;
    wlog.delete();
    spi_acc(lsb, 1'b0, a, n, d, q);
    check(19'(wlog.size()), 19'(nw));
    for (int i = 0; i < nw; i++) begin
      check(wlog[i], {4'h0, a + 7'(i), d[8*i +: 8]});
    end
  endtask

  // si carries junk during the read to show it is ignored
  task spi_rd(input logic lsb, input logic [6:0] a, input logic [15:0] e,
              input int nr);
    logic [15:0] q;
    int n0;
    n0 = nrd;
    spi_acc(lsb, 1'b1, a, 2, 16'h9696, q);
    check(19'(q), 19'(e));
    check(19'(nrd - n0), 19'(nr));
  endtask

  // select lifted in mid-byte drops the partial data byte
  task spi_abort();
    logic [7:0] g;
    wlog.delete();
    u_dmsp_host.spi_begin(1'b0);
    u_dmsp_host.spi_byte(8'h40, 8, g);
    u_dmsp_host.spi_byte(8'hff, 4, g);
    u_dmsp_host.spi_end();
    repeat (8) @(posedge clk);
    check(19'(wlog.size()), 19'h0);
    spi_wr(1'b0, 7'h41, 1, 16'h00c3, 1);
  endtask

  task spi_page();
    logic [15:0] q;
    spi_wr(1'b0, DMSP_PAGE_PTR_ADDR, 1, 16'h0003, 1);
    wlog.delete();
    spi_acc(1'b0, 1'b0, 7'h05, 1, 16'h0077, q);
    check(wlog[0], {4'h3, 7'h05, 8'h77});
  endtask

  // address byte with the pin bit high, ignored bit set, then data
  task i2c_wr(input logic [6:0] a, input int n, input logic [15:0] d);
    logic k;
    u_dmsp_host.i2c_start();
    u_dmsp_host.i2c_wbyte({SLV, 1'b1, 1'b0}, k);
    check(19'(k), 19'h1);
    u_dmsp_host.i2c_wbyte({1'b1, a}, k);
    check(19'(k), 19'h1);
    for (int i = 0; i < n; i++) begin
      u_dmsp_host.i2c_wbyte(d[8*i +: 8], k);
      check(19'(k), 19'h1);
    end
  endtask

  task i2c_scn();
    logic k;
    logic [15:0] q;
    u_dmsp_host.i2c_start();
    u_dmsp_host.i2c_wbyte({SLV, 1'b0, 1'b0}, k);
    u_dmsp_host.i2c_stop();
    check(19'(k), 19'h0);
    wlog.delete();
    i2c_wr(7'h30, 2, 16'h2211);
    u_dmsp_host.i2c_stop();
    check(19'(wlog.size()), 19'h2);
    check(wlog[0], {4'h0, 7'h30, 8'h11});
    check(wlog[1], {4'h0, 7'h31, 8'h22});
    i2c_wr(7'h30, 0, 16'h0000);
    u_dmsp_host.i2c_start();
    u_dmsp_host.i2c_wbyte({SLV, 1'b1, 1'b1}, k);
    u_dmsp_host.i2c_rbyte(1'b0, q[7:0]);
    u_dmsp_host.i2c_rbyte(1'b1, q[15:8]);
    u_dmsp_host.i2c_stop();
    check(19'(q), 19'h2211);
  endtask

  // main sequence: spi first, then i2c after a fresh reset
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    do_reset(1'b0);
    spi_wr(1'b0, 7'h10, 2, 16'h3ca5, 2);
    spi_wr(1'b1, 7'h18, 2, 16'h0f81, 2);
    spi_wr(1'b0, 7'h7f, 2, 16'h1234, 1);
    spi_rd(1'b1, 7'h20, 16'h7b7a, 3);
    spi_rd(1'b0, 7'h7f, 16'hff34, 1);
    spi_abort();
    spi_page();
    do_reset(1'b1);
    i2c_scn();
    conclude();
  end

  // a hang is cut short and counted
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
